// ---- hdl/asr_host_ctrl.sv ----
`timescale 1ns/1ps
module asr_host_ctrl
   import asr_pkg::*;
(
   // Clock and reset.
   input  wire logic              clk_i,
   input  wire logic              rstn_i,
   // User request.
   input  wire logic              req_i,
   input  wire logic              write_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   // User answer.
   output logic                   busy_o,
   output logic                   rvalid_o,
   output logic      [DATA_W-1:0] rdata_o,
   // Memory pins.
   output logic      [ADDR_W-1:0] address_lines_o,
   output logic                   chip_select_low_active_n_o,
   output logic                   chip_select_high_active_o,
   output logic                   output_enable_n_o,
   output logic                   write_enable_n_o,
   input  wire logic [DATA_W-1:0] data_lines_i,
   output logic      [DATA_W-1:0] data_lines_o,
   output logic                   data_lines_oe_o
);

   asr_state_t        state;
   asr_state_t        next_state;
   logic [CNT_W-1:0]  cnt;
   logic [CNT_W-1:0]  next_cnt;
   logic [ADDR_W-1:0] next_addr;
   logic              next_cs_n;
   logic              next_cs_h;
   logic              next_oe_n;
   logic              next_we_n;
   logic [DATA_W-1:0] next_dq;
   logic              next_dq_oe;
   logic [DATA_W-1:0] next_rdata;
   logic              next_rvalid;
   logic              next_busy;
   logic [DATA_W-1:0] dq_sync;

   // Read data pass two flip-flops before use.
   asr_sync #(
      .WIDTH   (DATA_W)
   ) u_dq_sync (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .async_i (data_lines_i),
      .sync_o  (dq_sync)
   );

   always_comb begin
      next_state  = state;
      next_cnt    = cnt;
      next_addr   = address_lines_o;
      next_cs_n   = chip_select_low_active_n_o;
      next_cs_h   = chip_select_high_active_o;
      next_oe_n   = output_enable_n_o;
      next_we_n   = write_enable_n_o;
      next_dq     = data_lines_o;
      next_dq_oe  = data_lines_oe_o;
      next_rdata  = rdata_o;
      next_rvalid = 1'h0;
      case (state)
         ST_IDLE: begin
            next_cs_n  = SEL_LOW_IDLE;
            next_cs_h  = SEL_HIGH_IDLE;
            next_oe_n  = OE_N_IDLE;
            next_we_n  = WE_N_IDLE;
            next_dq_oe = 1'h0;
            if (req_i) begin
               // Address moves only here, with write strobe high.
               next_addr = addr_i;
               next_cs_n = 1'h0;
               next_cs_h = 1'h1;
               if (write_i) begin
                  // Output enable stays high, so the memory never drives now.
                  next_dq    = wdata_i;
                  next_dq_oe = 1'h1;
                  next_state = ST_WSETUP;
               end else begin
                  next_oe_n  = 1'h0;
                  next_cnt   = RD_LOAD;
                  next_state = ST_RACCESS;
               end
            end
         end
         ST_WSETUP: begin
            // Strobe falls after select and address settle.
            next_we_n  = 1'h0;
            next_cnt   = WP_LOAD;
            next_state = ST_WPULSE;
         end
         ST_WPULSE: begin
            if (cnt == '0) begin
               next_we_n  = 1'h1;
               next_state = ST_WEND;
            end else begin
               next_cnt = cnt - 1'h1;
            end
         end
         ST_WEND: begin
            // Data and select are released one cycle after the strobe rises.
            next_dq_oe = 1'h0;
            next_cs_n  = SEL_LOW_IDLE;
            next_cs_h  = SEL_HIGH_IDLE;
            next_state = ST_IDLE;
         end
         ST_RACCESS: begin
            // Write strobe is held high for the whole read.
            next_we_n = WE_N_IDLE;
            if (cnt == '0) begin
               next_rdata  = dq_sync;
               next_rvalid = 1'h1;
               next_oe_n   = OE_N_IDLE;
               next_cs_n   = SEL_LOW_IDLE;
               next_cs_h   = SEL_HIGH_IDLE;
               next_state  = ST_REND;
            end else begin
               next_cnt = cnt - 1'h1;
            end
         end
         ST_REND: begin
            // One idle cycle lets the memory float before anyone drives.
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      next_busy = (next_state != ST_IDLE);
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state                      <= ST_IDLE;
         cnt                        <= '0;
         address_lines_o            <= '0;
         chip_select_low_active_n_o <= SEL_LOW_IDLE;
         chip_select_high_active_o  <= SEL_HIGH_IDLE;
         output_enable_n_o          <= OE_N_IDLE;
         write_enable_n_o           <= WE_N_IDLE;
         data_lines_o               <= '0;
         data_lines_oe_o            <= 1'h0;
         rdata_o                    <= '0;
         rvalid_o                   <= 1'h0;
         busy_o                     <= 1'h0;
      end else begin
         state                      <= next_state;
         cnt                        <= next_cnt;
         address_lines_o            <= next_addr;
         chip_select_low_active_n_o <= next_cs_n;
         chip_select_high_active_o  <= next_cs_h;
         output_enable_n_o          <= next_oe_n;
         write_enable_n_o           <= next_we_n;
         data_lines_o               <= next_dq;
         data_lines_oe_o            <= next_dq_oe;
         rdata_o                    <= next_rdata;
         rvalid_o                   <= next_rvalid;
         busy_o                     <= next_busy;
      end
   end

   // Cycle counters that only the checks below read.
   logic       selected;
   logic [7:0] sel_cnt;
   logic [7:0] we_low_cnt;
   logic [7:0] oe_low_cnt;
   assign selected = !chip_select_low_active_n_o && chip_select_high_active_o;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sel_cnt    <= '0;
         we_low_cnt <= '0;
         oe_low_cnt <= '0;
      end else begin
         sel_cnt    <= selected ? sel_cnt + 8'h01 : 8'h00;
         we_low_cnt <= !write_enable_n_o ? we_low_cnt + 8'h01 : 8'h00;
         oe_low_cnt <= !output_enable_n_o ? oe_low_cnt + 8'h01 : 8'h00;
      end
   end

   a_write_needs_select: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !write_enable_n_o |-> selected && output_enable_n_o)
      else $error("Write strobe low while chip not selected.");

   a_read_strobe_high: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !output_enable_n_o |-> write_enable_n_o && $past(write_enable_n_o))
      else $error("Write strobe low during a read.");

   a_addr_settle: assert property (@(posedge clk_i) disable iff (!rstn_i)
      $fell(write_enable_n_o) |-> $stable(address_lines_o) && selected)
      else $error("Address not settled when write strobe fell.");

   a_select_before_end: assert property (@(posedge clk_i) disable iff (!rstn_i)
      $rose(write_enable_n_o) |-> selected && sel_cnt >= 8'(WP_CYC + 1))
      else $error("Chip selected too briefly before end of write.");

   a_data_setup: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !write_enable_n_o |-> data_lines_oe_o && $stable(data_lines_o) && $past(data_lines_oe_o))
      else $error("Write data not valid during write pulse.");

   a_data_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
      $rose(write_enable_n_o) |-> data_lines_oe_o ##1 !data_lines_oe_o)
      else $error("Write data not released right after end of write.");

   a_addr_change: assert property (@(posedge clk_i) disable iff (!rstn_i)
      $changed(address_lines_o) |-> write_enable_n_o && $past(write_enable_n_o))
      else $error("Address changed while write strobe low.");

   a_pulse_width: assert property (@(posedge clk_i) disable iff (!rstn_i)
      $rose(write_enable_n_o) |-> we_low_cnt == 8'(WP_CYC))
      else $error("Write pulse width wrong.");

   a_no_contention: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (!output_enable_n_o || $past(!output_enable_n_o)) |-> !data_lines_oe_o)
      else $error("Controller drives data while memory may drive.");

   a_read_access: assert property (@(posedge clk_i) disable iff (!rstn_i)
      $fell(output_enable_n_o) |-> !rvalid_o [*3] ##1 rvalid_o)
      else $error("Read data captured at the wrong cycle.");

   a_read_cycles: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rvalid_o |-> oe_low_cnt == 8'(RD_CYC))
      else $error("Output enable low for wrong number of cycles.");

endmodule // asr_host_ctrl

// ---- hdl/asr_pkg.sv ----
package asr_pkg;

   // Pin widths of the memory.
   localparam int ADDR_W        = 18;
   localparam int DATA_W        = 8;

   // Clock of the controller.
   localparam int CLK_PERIOD_NS = 100;

   // Bus timing of the memory, in nanoseconds.
   localparam int T_AA_NS       = 55;
   localparam int T_OE_NS       = 30;
   localparam int T_HZ_NS       = 20;
   localparam int T_AW_NS       = 50;
   localparam int T_CW_NS       = 50;
   localparam int T_WP_NS       = 45;
   localparam int T_DW_NS       = 25;
   localparam int T_WHZ_NS      = 20;

   // Stages of the data input synchroniser.
   localparam int SYNC_STAGES   = 2;

   // Least times rounded up to whole cycles.
   localparam int AA_NEED_NS    = (T_AA_NS > T_OE_NS) ? T_AA_NS : T_OE_NS;
   localparam int AA_CYC        = (AA_NEED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RD_CYC        = AA_CYC + SYNC_STAGES;
   localparam int WP_MIN1_NS    = (T_WP_NS > T_AW_NS) ? T_WP_NS : T_AW_NS;
   localparam int WP_MIN2_NS    = (WP_MIN1_NS > T_CW_NS) ? WP_MIN1_NS : T_CW_NS;
   localparam int WP_OVL_NS     = T_WHZ_NS + T_DW_NS + 1;
   localparam int WP_NEED_NS    = (WP_MIN2_NS > WP_OVL_NS) ? WP_MIN2_NS : WP_OVL_NS;
   localparam int WP_CYC        = (WP_NEED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HZ_CYC        = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Cycle counter loads.
   localparam int CNT_W         = 4;
   localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(RD_CYC - 1);
   localparam logic [CNT_W-1:0] WP_LOAD = CNT_W'(WP_CYC - 1);

   // Idle pin levels.
   localparam logic SEL_LOW_IDLE  = 1'h1;
   localparam logic SEL_HIGH_IDLE = 1'h0;
   localparam logic OE_N_IDLE     = 1'h1;
   localparam logic WE_N_IDLE     = 1'h1;

   typedef enum logic [5:0] {
      ST_IDLE    = 6'h01,
      ST_WSETUP  = 6'h02,
      ST_WPULSE  = 6'h04,
      ST_WEND    = 6'h08,
      ST_RACCESS = 6'h10,
      ST_REND    = 6'h20
   } asr_state_t;

endpackage

// ---- hdl/asr_sync.sv ----
`timescale 1ns/1ps
module asr_sync
   import asr_pkg::*;
#(
   parameter int WIDTH = DATA_W
) (
   // Clock and reset.
   input  wire logic             clk_i,
   input  wire logic             rstn_i,
   // Asynchronous input and its synchronised copy.
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   // Each bit passes two flip-flops; the first feeds only the second.
   for (genvar b = 0; b < WIDTH; b++) begin : g_bit
      logic meta;
      always_ff @(posedge clk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            meta      <= 1'h0;
            sync_o[b] <= 1'h0;
         end else begin
            meta      <= async_i[b];
            sync_o[b] <= meta;
         end
      end
   end

endmodule // asr_sync

// ---- tb/asr_mem_model.sv ----
`timescale 1ns/1ps
module asr_mem_model
   import asr_pkg::*;
(
   // Answer speed select.
   input  wire logic              slow_i,
   // Memory pins from the controller.
   input  wire logic [ADDR_W-1:0] address_lines_i,
   input  wire logic              chip_select_low_active_n_i,
   input  wire logic              chip_select_high_active_i,
   input  wire logic              output_enable_n_i,
   input  wire logic              write_enable_n_i,
   // Resolved data wire and controller drive enable.
   input  wire logic [DATA_W-1:0] data_lines_i,
   input  wire logic              ctrl_oe_i,
   // Memory drive and count of bus faults seen.
   output logic      [DATA_W-1:0] data_lines_o,
   output logic                   data_lines_oe_o,
   output int                     viol_o
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   realtime           t_addr;
   realtime           t_sel;
   realtime           t_data;
   wire               sel = !chip_select_low_active_n_i && chip_select_high_active_i;
   wire               rd  = sel && !output_enable_n_i && write_enable_n_i;
   wire               wr  = sel && !write_enable_n_i;

   initial begin
      viol_o = 0;
      data_lines_o = 8'h00;
      data_lines_oe_o = 1'h0;
      t_addr = 0;
      t_sel = 0;
      t_data = 0;
   end

   always @(address_lines_i) begin
      t_addr = $realtime;
      if (wr) viol_o++;
   end

   always @(posedge sel) t_sel = $realtime;

   always @(data_lines_i) t_data = $realtime;

   // Old data stays briefly, then garbage until the access time ends.
   always @(rd or address_lines_i) begin
      data_lines_o <= #10 ~data_lines_o;
      data_lines_o <= #(slow_i ? T_AA_NS : 10) mem[address_lines_i];
   end

   always @(rd) data_lines_oe_o <= #(rd ? 5 : T_HZ_NS) rd;

   always @(negedge wr) begin
      if (t_sel > 0) begin
         if ($realtime - t_addr < T_AW_NS) viol_o++;
         if ($realtime - t_sel < T_CW_NS) viol_o++;
         if ($realtime - t_data < T_DW_NS) viol_o++;
         mem[address_lines_i] = data_lines_i;
      end
   end

   always @(ctrl_oe_i or data_lines_oe_o) begin
      if (ctrl_oe_i && data_lines_oe_o) viol_o++;
   end
endmodule // asr_mem_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench
   import asr_pkg::*;
;
   logic              clk_i = 1'h0;
   logic              rstn_i, req_i, write_i, slow_i, busy_o, rvalid_o;
   logic [ADDR_W-1:0] addr_i, address_lines_o;
   logic [DATA_W-1:0] wdata_i, rdata_o, data_lines_o, mem_dq, data_wire;
   logic [DATA_W-1:0] float_q = 8'h5a;
   logic              cs_n, cs_h, oe_n, we_n, data_lines_oe_o, mem_oe;
   int                viol, errors = 0, compares = 0;
   logic [ADDR_W-1:0] ta [5] = '{18'h00000, 18'h00001, 18'h3ffff, 18'h20000, 18'h15555};
   logic [DATA_W-1:0] td [5] = '{8'ha5, 8'h5a, 8'hff, 8'h00, 8'h3c};

   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) float_q <= ~float_q;
   assign data_wire = data_lines_oe_o ? data_lines_o : (mem_oe ? mem_dq : float_q);

   asr_host_ctrl u_asr_host_ctrl (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i), .write_i(write_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .busy_o(busy_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o),
      .address_lines_o(address_lines_o), .chip_select_low_active_n_o(cs_n), .chip_select_high_active_o(cs_h),
      .output_enable_n_o(oe_n), .write_enable_n_o(we_n), .data_lines_i(data_wire),
      .data_lines_o(data_lines_o), .data_lines_oe_o(data_lines_oe_o));

   asr_mem_model u_asr_mem_model (.slow_i(slow_i), .address_lines_i(address_lines_o),
      .chip_select_low_active_n_i(cs_n), .chip_select_high_active_i(cs_h), .output_enable_n_i(oe_n),
      .write_enable_n_i(we_n), .data_lines_i(data_wire), .ctrl_oe_i(data_lines_oe_o),
      .data_lines_o(mem_dq), .data_lines_oe_o(mem_oe), .viol_o(viol));

   task automatic summarize();
      $display("Comparisons %0d, errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_idle();
      int n;
      for (n = 0; n < 10 && busy_o !== 1'b0; n++) @(negedge clk_i);
      if (n == 10) begin
         errors++;
         summarize();
      end
   endtask

   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] q, output int wl, output int ol);
      int n;
      q = 'x;
      wl = 0;
      ol = 0;
      @(negedge clk_i);
      req_i = 1'h1;
      write_i = w;
      addr_i = a;
      wdata_i = d;
      @(negedge clk_i);
      req_i = 1'h0;
      for (n = 0; n < 10 && busy_o !== 1'b0; n++) begin
         if (we_n === 1'b0) wl++;
         if (oe_n === 1'b0) ol++;
         if (rvalid_o === 1'b1) q = rdata_o;
         @(negedge clk_i);
      end
      if (n == 10) begin
         errors++;
         summarize();
      end
   endtask

   task automatic t_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] q;
      int                wl, ol;
      xfer(1'h1, a, d, q, wl, ol);
      chk(wl, WP_CYC);
      chk(ol, 0);
      chk(address_lines_o, a);
   endtask

   task automatic t_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      logic [DATA_W-1:0] q;
      int                wl, ol;
      xfer(1'h0, a, 8'h00, q, wl, ol);
      chk(q, e);
      chk(wl, 0);
      chk(ol, RD_CYC);
   endtask

   task automatic t_idle();
      chk(cs_n, 1'h1);
      chk(cs_h, 1'h0);
      chk(we_n, 1'h1);
      chk(oe_n, 1'h1);
      chk(data_lines_oe_o, 1'h0);
      chk(busy_o, 1'h0);
   endtask

   task automatic t_bounds();
      for (int i = 0; i < 5; i++) t_write(ta[i], td[i]);
      for (int i = 0; i < 5; i++) t_read(ta[i], td[i]);
   endtask

   task automatic t_slow();
      slow_i = 1'h1;
      for (int i = 4; i >= 0; i--) t_read(ta[i], td[i]);
      slow_i = 1'h0;
   endtask

   task automatic t_refuse();
      t_write(18'h00100, 8'h11);
      @(negedge clk_i);
      req_i = 1'h1;
      write_i = 1'h1;
      addr_i = 18'h00200;
      wdata_i = 8'h22;
      @(negedge clk_i);
      addr_i = 18'h00100;
      wdata_i = 8'hee;
      @(negedge clk_i);
      @(negedge clk_i);
      req_i = 1'h0;
      wait_idle();
      t_read(18'h00100, 8'h11);
      t_read(18'h00200, 8'h22);
   endtask

   task automatic t_abort();
      @(negedge clk_i);
      req_i = 1'h1;
      write_i = 1'h1;
      addr_i = 18'h00300;
      wdata_i = 8'h33;
      @(negedge clk_i);
      req_i = 1'h0;
      chk(we_n, 1'h1);
      chk(data_lines_oe_o, 1'h1);
      rstn_i = 1'h0;
      #1;
      t_idle();
      @(negedge clk_i);
      rstn_i = 1'h1;
      t_read(18'h00001, 8'h5a);
   endtask

   initial begin
      rstn_i = 1'h0;
      req_i = 1'h0;
      write_i = 1'h0;
      addr_i = 18'h00000;
      wdata_i = 8'h00;
      slow_i = 1'h0;
      repeat (12) @(posedge clk_i);
      @(negedge clk_i);
      rstn_i = 1'h1;
      t_idle();
      t_bounds();
      t_slow();
      t_refuse();
      t_abort();
      chk(viol, 0);
      summarize();
   end
endmodule // testbench
